/* verilog/clamp_pkg.sv */
// Constants and types for the converter clamp register bank.
// Assumes a 32-bit AXI4-Lite master with byte addresses.
package clamp_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] CODE_IDX = 8'h05;
	localparam logic [7:0] SEL_IDX = 8'h06;
	localparam logic [7:0] CFG_IDX = 8'h07;
	localparam logic [7:0] CODE_ADDR = 8'h14;
	localparam logic [7:0] SEL_ADDR = 8'h18;
	localparam logic [7:0] CFG_ADDR = 8'h1C;
	localparam logic [15:0] CODE_RST = 16'h0000;
	localparam logic [15:0] SEL_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam int NCONV = 4;
	localparam int CFG_W = 12;
	localparam int RANGE_W = 4;
	// ----------------------------------------
	// Fields and codes
	// ----------------------------------------
	localparam logic [1:0] POL_TRACK = 2'h0;
	localparam logic [1:0] POL_USER = 2'h1;
	localparam logic [1:0] POL_AUTO = 2'h2;
	localparam logic [1:0] POL_BAD = 2'h3;
	localparam logic [3:0] PCL_VOLT_OK = 4'h3;
	localparam logic [3:0] NCL_VOLT_9 = 4'h2;
	localparam logic [3:0] NCL_VOLT_15 = 4'h7;
	localparam logic [3:0] NCL_VOLT_18 = 4'h9;
	localparam logic [3:0] RANGE_CUR_LO = 4'h4;
	localparam logic [3:0] RANGE_CUR_HI = 4'h7;
	localparam logic [2:0] RANGE_CUR_TOP = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// Field order matches bits 11:0 of the config word
	typedef struct packed {
		logic [1:0] policy;
		logic [3:0] pclamp;
		logic [3:0] nclamp;
		logic [1:0] arm;
	} conv_cfg_s;
	typedef conv_cfg_s [NCONV-1:0] conv_cfg_arr_t;
endpackage : clamp_pkg

/* verilog/clamp_regs.sv */
// Conversion code, converter select and converter clamp config registers.
// Assumes AXI4-Lite master on CLK; range and learn inputs are CLK-synchronous.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] A 16-bit read/write code register at index 0x05 drives the converter code.
// [RULE2] A 16-bit read/write select register at index 0x06 resets to zero, reserved bits too.
// [RULE3] Select bits 0 to 3 pick supply converters A to D and reset to zero.
// [RULE4] A 16-bit read/write config register at index 0x07 resets to zero, bits 15:12 reserved.
// [RULE5] Clamp policy sits in bits 11:10, resets to 00, and code 11 is never taken.
// [RULE6] Policy 00 is full tracking and applies no user clamp levels.
// [RULE7] Policy 01 lets software write both clamp level fields.
// [RULE8] Policy 10 loads the positive clamp from the learn logic and ignores writes to it.
// [RULE9] Positive clamp sits in bits 9:6; in voltage mode only code 0011 is valid.
// [RULE10] Negative clamp sits in bits 5:2; in voltage mode only 0010, 0111 and 1001 are valid.
// [RULE11] Arm enable in bits 1:0 enables neither, positive, negative or both arms.
// [RULE12] Range codes 0100 to 0111 and 111x mean current mode, other codes voltage mode.
// [RULE13] Config writes go to every selected converter; reads return the first selected one.
// [RULE14] Reserved bits have no effect; select keeps them, config reads them as zero.
module clamp_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	input wire logic [15:0] RANGE_IN,
	input wire logic [15:0] AUTO_PCLAMP,
	output logic [15:0] CODE_OUT,
	output clamp_pkg::conv_cfg_arr_t CONV_CFG,
	output logic [3:0] CLAMP_APPLY,
	output logic [3:0] CURRENT_MODE,
	output logic [3:0] ARM_POS,
	output logic [3:0] ARM_NEG,
	output logic [3:0] CLAMP_INVALID
);
	import clamp_pkg::*;
	if (ADDR_W < 8) begin : g_chk
		$error("ADDR_W must be at least 8");
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[15:8] = d[15:8];
		return r;
	endfunction : wr16
	function automatic logic is_cur(input logic [3:0] rng);
		return (rng >= RANGE_CUR_LO && rng <= RANGE_CUR_HI) || rng[3:1] == RANGE_CUR_TOP; // RULE12
	endfunction : is_cur
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
		return a == ADDR_W'(reg_addr);
	endfunction : hit

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_e;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_e;
	wr_e wr_state_reg, wr_state_next;
	rd_e rd_state_reg, rd_state_next;
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [ADDR_W-1:0] waddr_reg, waddr_next;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic [15:0] code_reg, code_next, sel_reg, sel_next;
	conv_cfg_arr_t cfg_reg, cfg_next;
	logic [3:0] apply_reg, apply_next, cur_reg, cur_next;
	logic [3:0] apos_reg, apos_next, aneg_reg, aneg_next, inv_reg, inv_next;
	logic commit, aw_hs, w_hs, ar_hs, w_hit;
	assign aw_hs = S_AXI_AWVALID && awready_reg;
	assign w_hs = S_AXI_WVALID && wready_reg;
	assign ar_hs = S_AXI_ARVALID && arready_reg;
	assign commit = wr_state_reg == WR_IDLE && aw_have_reg && w_have_reg;
	assign w_hit = hit(waddr_reg, CODE_ADDR) || hit(waddr_reg, SEL_ADDR) ||
		hit(waddr_reg, CFG_ADDR);

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	// Address and data are taken in either order, then answered together
	always_comb begin
		wr_state_next = wr_state_reg;
		aw_have_next = aw_have_reg || aw_hs;
		w_have_next = w_have_reg || w_hs;
		waddr_next = aw_hs ? S_AXI_AWADDR : waddr_reg;
		wdata_next = w_hs ? S_AXI_WDATA : wdata_reg;
		wstrb_next = w_hs ? S_AXI_WSTRB : wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		unique case (wr_state_reg)
			WR_IDLE: begin
				if (commit) begin
					wr_state_next = WR_RESP;
					bvalid_next = 1'b1;
					bresp_next = w_hit ? RESP_OKAY : RESP_DECERR;
					aw_have_next = 1'b0;
					w_have_next = 1'b0;
				end
			end
			WR_RESP: begin
				if (S_AXI_BREADY) begin
					wr_state_next = WR_IDLE;
					bvalid_next = 1'b0;
				end
			end
		endcase
		awready_next = wr_state_next == WR_IDLE && !aw_have_next;
		wready_next = wr_state_next == WR_IDLE && !w_have_next;
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_state_reg <= WR_IDLE;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			wr_state_reg <= wr_state_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
		logic [31:0] r;
		r = 32'h00000000;
		if (hit(a, CODE_ADDR)) r[15:0] = code_reg; // RULE1
		if (hit(a, SEL_ADDR)) r[15:0] = sel_reg; // RULE2
		if (hit(a, CFG_ADDR)) begin
			// Lowest selected converter answers; none selected reads zero
			for (int i = NCONV - 1; i >= 0; i--) begin
				if (sel_reg[i]) r[CFG_W-1:0] = cfg_reg[i]; // RULE13 RULE4
			end
		end
		return r;
	endfunction : rd_mux
	always_comb begin
		rd_state_next = rd_state_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		unique case (rd_state_reg)
			RD_IDLE: begin
				if (ar_hs) begin
					rd_state_next = RD_DATA;
					rvalid_next = 1'b1;
					rdata_next = rd_mux(S_AXI_ARADDR);
					rresp_next = (hit(S_AXI_ARADDR, CODE_ADDR) || hit(S_AXI_ARADDR, SEL_ADDR) ||
						hit(S_AXI_ARADDR, CFG_ADDR)) ? RESP_OKAY : RESP_DECERR;
				end
			end
			RD_DATA: begin
				if (S_AXI_RREADY) begin
					rd_state_next = RD_IDLE;
					rvalid_next = 1'b0;
				end
			end
		endcase
		arready_next = rd_state_next == RD_IDLE;
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rd_state_reg <= RD_IDLE;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else begin
			rd_state_reg <= rd_state_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// ----------------------------------------
	// Registers and converter controls
	// ----------------------------------------
	always_comb begin
		logic [15:0] nv;
		conv_cfg_s nc;
		nv = 16'h0000;
		nc = '0;
		code_next = code_reg;
		sel_next = sel_reg;
		cfg_next = cfg_reg;
		if (commit && hit(waddr_reg, CODE_ADDR)) code_next = wr16(code_reg, wdata_reg, wstrb_reg); // RULE1
		// Reserved select bits are stored but steer nothing
		if (commit && hit(waddr_reg, SEL_ADDR)) sel_next = wr16(sel_reg, wdata_reg, wstrb_reg); // RULE2 RULE14
		for (int i = 0; i < NCONV; i++) begin
			if (commit && hit(waddr_reg, CFG_ADDR) && sel_reg[i]) begin // RULE3 RULE13
				nv = wr16({4'h0, cfg_reg[i]}, wdata_reg, wstrb_reg);
				nc = nv[CFG_W-1:0]; // RULE4 RULE14
				if (nc.policy == POL_BAD) nc.policy = cfg_reg[i].policy; // RULE5
				if (nc.policy != POL_USER) nc.pclamp = cfg_reg[i].pclamp; // RULE7 RULE8
				if (nc.policy == POL_TRACK) nc.nclamp = cfg_reg[i].nclamp; // RULE6
				cfg_next[i] = nc;
			end
			// Learn logic owns the positive clamp while auto-learn holds
			if (cfg_next[i].policy == POL_AUTO) cfg_next[i].pclamp = AUTO_PCLAMP[4*i +: 4]; // RULE8
		end
		for (int i = 0; i < NCONV; i++) begin
			apply_next[i] = cfg_next[i].policy != POL_TRACK; // RULE6
			cur_next[i] = is_cur(RANGE_IN[RANGE_W*i +: RANGE_W]); // RULE12
			apos_next[i] = cfg_next[i].arm[0]; // RULE11
			aneg_next[i] = cfg_next[i].arm[1]; // RULE11
			// Flag only; voltage mode cannot serve most clamp codes
			inv_next[i] = apply_next[i] && !cur_next[i] &&
				(cfg_next[i].pclamp != PCL_VOLT_OK || // RULE9
				!(cfg_next[i].nclamp inside {NCL_VOLT_9, NCL_VOLT_15, NCL_VOLT_18})); // RULE10
		end
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			code_reg <= CODE_RST;
			sel_reg <= SEL_RST;
			cfg_reg <= {NCONV{CFG_RST[CFG_W-1:0]}};
			apply_reg <= 4'h0;
			cur_reg <= 4'h0;
			apos_reg <= 4'h0;
			aneg_reg <= 4'h0;
			inv_reg <= 4'h0;
		end else begin
			code_reg <= code_next;
			sel_reg <= sel_next;
			cfg_reg <= cfg_next;
			apply_reg <= apply_next;
			cur_reg <= cur_next;
			apos_reg <= apos_next;
			aneg_reg <= aneg_next;
			inv_reg <= inv_next;
		end
	end
	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign CODE_OUT = code_reg;
	assign CONV_CFG = cfg_reg;
	assign CLAMP_APPLY = apply_reg;
	assign CURRENT_MODE = cur_reg;
	assign ARM_POS = apos_reg;
	assign ARM_NEG = aneg_reg;
	assign CLAMP_INVALID = inv_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_wr(logic [7:0] a);
		commit && hit(waddr_reg, a) && wstrb_reg[1:0] == 2'h3;
	endsequence
	property p_code;
		s_wr(CODE_ADDR) |=> CODE_OUT == $past(wdata_reg[15:0]) && S_AXI_BVALID;
	endproperty
	a_code: assert property (p_code) else $error("code write lost"); // RULE1
	property p_sel;
		s_wr(SEL_ADDR) |=> sel_reg == $past(wdata_reg[15:0]);
	endproperty
	a_sel: assert property (p_sel) else $error("select write lost"); // RULE2
	property p_cfg_rsv;
		S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000;
	endproperty
	a_cfg_rsv: assert property (p_cfg_rsv) else $error("upper read bits set"); // RULE4
	property p_pol;
		CONV_CFG[0].policy != POL_BAD;
	endproperty
	a_pol: assert property (p_pol) else $error("invalid policy held"); // RULE5
	property p_track;
		CONV_CFG[0].policy == POL_TRACK |-> !CLAMP_APPLY[0];
	endproperty
	a_track: assert property (p_track) else $error("clamp applied in tracking"); // RULE6
	property p_user;
		s_wr(CFG_ADDR) ##0 (sel_reg[0] && wdata_reg[11:10] == POL_USER) |=>
			CONV_CFG[0].pclamp == $past(wdata_reg[9:6]) && CONV_CFG[0].nclamp == $past(wdata_reg[5:2]);
	endproperty
	a_user: assert property (p_user) else $error("user clamp write lost"); // RULE7
	property p_auto;
		CONV_CFG[0].policy == POL_AUTO |-> CONV_CFG[0].pclamp == $past(AUTO_PCLAMP[3:0]);
	endproperty
	a_auto: assert property (p_auto) else $error("auto clamp not loaded"); // RULE8
	property p_arm;
		ARM_POS[0] == CONV_CFG[0].arm[0] && ARM_NEG[0] == CONV_CFG[0].arm[1];
	endproperty
	a_arm: assert property (p_arm) else $error("arm enables wrong"); // RULE11
	property p_inv;
		CLAMP_APPLY[0] && !CURRENT_MODE[0] && CONV_CFG[0].pclamp != PCL_VOLT_OK |-> CLAMP_INVALID[0];
	endproperty
	a_inv: assert property (p_inv) else $error("invalid clamp not flagged"); // RULE9 RULE12
	property p_rd;
		ar_hs |=> S_AXI_RVALID && !S_AXI_ARREADY;
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered"); // RULE13
endmodule : clamp_regs
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the converter clamp register bank.
// Assumes clamp_regs with 8-bit byte addresses; assertions live in the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import clamp_pkg::*;
	logic CLK = 1'b0, ARST_N = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid;
	logic [15:0] range_in = 16'h0000, auto_pclamp = 16'h0000, code_out;
	conv_cfg_arr_t conv_cfg;
	logic [3:0] apply, cur_mode, arm_pos, arm_neg, invalid;
	int bad_count = 0, check_count = 0;
	logic [31:0] d;
	logic [1:0] r;
	clamp_regs #(.ADDR_W(8)) dut (.CLK(CLK), .ARST_N(ARST_N), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .RANGE_IN(range_in), .AUTO_PCLAMP(auto_pclamp),
		.CODE_OUT(code_out), .CONV_CFG(conv_cfg), .CLAMP_APPLY(apply),
		.CURRENT_MODE(cur_mode), .ARM_POS(arm_pos), .ARM_NEG(arm_neg),
		.CLAMP_INVALID(invalid));
	initial begin
		forever #12.5 CLK = ~CLK;
	end
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Both channels offered together; each dropped at its own handshake edge
	task axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		logic aw_done, w_done;
		n = 0;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge CLK);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= v;
		// Own flags, since a pending drop of valid is not yet visible here
		while (!(aw_done && w_done)) begin
			@(posedge CLK);
			n++;
			if (!aw_done && awready) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		bready <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
		check(n >= 100, 1'b0);
	endtask : axi_write
	task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge CLK);
		arvalid <= 1'b1;
		araddr <= a;
		do begin
			@(posedge CLK);
			n++;
		end while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (!rvalid);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
		check(n >= 100, 1'b0);
	endtask : axi_read
	// Derived outputs register on the same edge as the config; range mode lags RANGE_IN by a cycle
	task settle();
		repeat (2) @(posedge CLK);
		#1;
	endtask : settle
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset();
		axi_read(CODE_ADDR, d, r); check(d, 32'h0);
		axi_read(SEL_ADDR, d, r); check(d, 32'h0);
		axi_read(CFG_ADDR, d, r); check(d, 32'h0);
		check({16'h0, arm_pos, arm_neg, apply, invalid}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task t_code_sel();
		axi_write(CODE_ADDR, 32'h0000A5C3, r); check(r, RESP_OKAY);
		axi_read(CODE_ADDR, d, r); check(d, 32'h0000A5C3);
		check(code_out, 16'hA5C3);
		axi_write(SEL_ADDR, 32'h0000FFF5, r);
		axi_read(SEL_ADDR, d, r); check(d, 32'h0000FFF5);
		$display("test code and select done");
	endtask : t_code_sel
	task t_user();
		axi_write(CFG_ADDR, 32'h0000F4DF, r);
		axi_read(CFG_ADDR, d, r); check(d, 32'h000004DF);
		settle();
		check(conv_cfg[0], 12'h4DF);
		check(conv_cfg[2], 12'h4DF);
		check({conv_cfg[3], conv_cfg[1]}, 24'h0);
		check({arm_pos, arm_neg, apply}, 12'h555);
		check(invalid, 4'h0);
		$display("test user clamps done");
	endtask : t_user
	task t_modes();
		@(posedge CLK);
		range_in <= 16'hE740;
		axi_write(CFG_ADDR, 32'h0000055F, r);
		settle();
		check(cur_mode, 4'hE);
		check(invalid, 4'h1);
		axi_write(CFG_ADDR, 32'h000004E3, r);
		settle();
		check(invalid, 4'h1);
		axi_write(CFG_ADDR, 32'h000004E7, r);
		settle();
		check(invalid, 4'h0);
		$display("test output modes done");
	endtask : t_modes
	task t_auto();
		@(posedge CLK);
		auto_pclamp <= 16'h0909;
		axi_write(CFG_ADDR, 32'h00000889, r);
		settle();
		axi_read(CFG_ADDR, d, r); check(d, 32'h00000A49);
		check(conv_cfg[2], 12'hA49);
		auto_pclamp <= 16'h0606;
		settle();
		axi_read(CFG_ADDR, d, r); check(d, 32'h00000989);
		$display("test auto learn done");
	endtask : t_auto
	task t_bad_pol();
		axi_write(CFG_ADDR, 32'h00000C26, r);
		axi_read(CFG_ADDR, d, r); check(d & 32'hC03, 32'h00000802);
		settle();
		check({arm_pos[0], arm_neg[0]}, 2'b01);
		axi_write(CFG_ADDR, 32'h00000143, r);
		axi_read(CFG_ADDR, d, r); check(d & 32'hC03, 32'h00000003);
		settle();
		check({apply, invalid}, 8'h00);
		$display("test policy codes done");
	endtask : t_bad_pol
	task t_select_map();
		axi_write(SEL_ADDR, 32'h00000000, r);
		axi_read(CFG_ADDR, d, r); check(d, 32'h0);
		axi_write(SEL_ADDR, 32'h00000002, r);
		axi_read(CFG_ADDR, d, r); check(d, 32'h0);
		axi_write(8'h20, 32'h0000FFFF, r); check(r, RESP_DECERR);
		axi_read(8'h20, d, r); check(d, 32'h0);
		check(r, RESP_DECERR);
		axi_read(CODE_ADDR, d, r); check(d, 32'h0000A5C3);
		$display("test select and map done");
	endtask : t_select_map
	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task report_and_stop();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge CLK);
		ARST_N <= 1'b1;
		t_reset();
		t_code_sel();
		t_user();
		t_modes();
		t_auto();
		t_bad_pol();
		t_select_map();
		report_and_stop();
	end
	// Whole run needs about 110 cycles; over forty times that is a hang
	initial begin
		repeat (5000) @(posedge CLK);
		bad_count++;
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
